/* File: inc/sdri_pkg.sv */
// package of constants for the step/direction reference input block
package sdri_pkg;
	// reference input modes selected by the drive configuration
	typedef enum logic {
		SDRI_MODE_STEP_DIR,
		SDRI_MODE_QUAD
	} sdri_mode_t;

	// step direction as commanded to the motor
	localparam logic SDRI_DIR_POS = 1'b0;
	localparam logic SDRI_DIR_NEG = 1'b1;

	// system clock rate and ready delay
	localparam int SDRI_CLK_HZ = 10000000;
	localparam int SDRI_READY_DELAY_MS = 100;
	localparam int SDRI_READY_CYCLES = SDRI_CLK_HZ / 1000 * SDRI_READY_DELAY_MS;

	// input rate limits expected from the controller
	localparam int SDRI_MAX_IN_HZ = 200000;
	localparam int SDRI_MIN_EDGE_CYCLES = SDRI_CLK_HZ / (2 * SDRI_MAX_IN_HZ);

	// synchroniser depth
	localparam int SDRI_SYNC_STAGES = 2;
endpackage : sdri_pkg

/* File: rtl/sdri_sync.sv */
// two-flop synchroniser bank for the reference inputs
`timescale 1ns/1ps
`default_nettype none
module sdri_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// next values: first stage feeds only the second
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : sdri_sync
`default_nettype wire

/* File: rtl/sdri_top.sv */
// reference value input logic: step/direction or quadrature, plus drive ready
`timescale 1ns/1ps
`default_nettype none
module sdri_top
	import sdri_pkg::*;
#(
	parameter int READY_CYCLES = SDRI_READY_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire sdri_pkg::sdri_mode_t ref_mode,
	input wire logic step_strobe,
	input wire logic rotation_sense,
	input wire logic ref_channel_a,
	input wire logic ref_channel_b,
	input wire logic ref_index,
	input wire logic stage_enable,
	input wire logic drive_error,
	output logic motor_step,
	output logic motor_dir,
	output logic index_seen,
	output logic drive_ready_n_o,
	output logic drive_ready_n_oe
);
	import sdri_pkg::*;

	localparam int CNT_W = $clog2(READY_CYCLES + 1);
	localparam logic [CNT_W-1:0] READY_LAST = CNT_W'(READY_CYCLES - 1);

	// synchronised inputs: strobe, sense, a, b, index
	logic [4:0] raw_in;
	logic [4:0] syn_in;
	assign raw_in = {step_strobe, rotation_sense, ref_channel_a, ref_channel_b, ref_index};

	// all reference inputs pass a two-flop synchroniser
	sdri_sync #(
		.WIDTH(5)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(raw_in),
		.sync_out(syn_in)
	);

	logic s_step, s_sense, s_a, s_b, s_idx;
	assign s_step = syn_in[4];
	assign s_sense = syn_in[3];
	assign s_a = syn_in[2];
	assign s_b = syn_in[1];
	assign s_idx = syn_in[0];

	// previous synchronised levels for edge detection
	logic step_prev_q, step_prev_d;
	logic a_prev_q, a_prev_d;
	logic b_prev_q, b_prev_d;
	logic idx_prev_q, idx_prev_d;
	logic step_q, step_d;
	logic dir_q, dir_d;
	logic index_q, index_d;

	// quadrature decode: previous state vs current state gives direction
	function automatic logic [1:0] sdri_quad(input logic pa, input logic pb,
			input logic ca, input logic cb);
		logic [3:0] tr;
		tr = {pa, pb, ca, cb};
		case (tr)
			4'h1, 4'h7, 4'hE, 4'h8: sdri_quad = 2'h2; // b leads a: forward
			4'h2, 4'hB, 4'hD, 4'h4: sdri_quad = 2'h3; // a leads b: reverse
			default: sdri_quad = 2'h0; // no move or illegal double change
		endcase
	endfunction : sdri_quad

	logic [1:0] quad;
	assign quad = sdri_quad(a_prev_q, b_prev_q, s_a, s_b);

	// next step command and direction
	always_comb begin
		step_prev_d = s_step;
		a_prev_d = s_a;
		b_prev_d = s_b;
		idx_prev_d = s_idx;
		step_d = 1'b0;
		dir_d = dir_q;
		index_d = 1'b0;
		case (ref_mode)
			SDRI_MODE_STEP_DIR: begin
				if (s_step && !step_prev_q) begin
					step_d = 1'b1;
					// sense low (or open, pulled low) is positive
					dir_d = s_sense ? SDRI_DIR_NEG : SDRI_DIR_POS;
				end
			end
			SDRI_MODE_QUAD: begin
				if (quad[1]) begin
					step_d = 1'b1;
					dir_d = quad[0] ? SDRI_DIR_NEG : SDRI_DIR_POS;
				end
				index_d = s_idx && !idx_prev_q;
			end
			default: begin
				step_d = 1'b0;
			end
		endcase
	end

	// register step command state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			step_prev_q <= 1'b0;
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
			idx_prev_q <= 1'b0;
			step_q <= 1'b0;
			dir_q <= SDRI_DIR_POS;
			index_q <= 1'b0;
		end else begin
			step_prev_q <= step_prev_d;
			a_prev_q <= a_prev_d;
			b_prev_q <= b_prev_d;
			idx_prev_q <= idx_prev_d;
			step_q <= step_d;
			dir_q <= dir_d;
			index_q <= index_d;
		end
	end

	assign motor_step = step_q;
	assign motor_dir = dir_q;
	assign index_seen = index_q;

	// readiness sequencing after power stage enable
	typedef enum logic [1:0] {
		SDRI_RDY_OFF,
		SDRI_RDY_WAIT,
		SDRI_RDY_ON
	} sdri_rdy_t;

	sdri_rdy_t rdy_q, rdy_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;

	// next readiness state; error or disable drops readiness at once
	always_comb begin
		rdy_d = rdy_q;
		cnt_d = cnt_q;
		case (rdy_q)
			SDRI_RDY_OFF: begin
				cnt_d = '0;
				if (stage_enable && !drive_error) begin
					rdy_d = SDRI_RDY_WAIT;
				end
			end
			SDRI_RDY_WAIT: begin
				if (!stage_enable || drive_error) begin
					rdy_d = SDRI_RDY_OFF;
				end else if (cnt_q == READY_LAST) begin
					rdy_d = SDRI_RDY_ON;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			SDRI_RDY_ON: begin
				if (!stage_enable || drive_error) begin
					rdy_d = SDRI_RDY_OFF;
				end
			end
			default: begin
				rdy_d = SDRI_RDY_OFF;
			end
		endcase
		ready_d = (rdy_d == SDRI_RDY_ON);
	end

	// register readiness state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdy_q <= SDRI_RDY_OFF;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end

	// open collector: drive low when ready, release otherwise
	assign drive_ready_n_o = 1'b0;
	assign drive_ready_n_oe = ready_q;

	// assertions
	a_step_on_edge: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_STEP_DIR && s_step && !step_prev_q) |=> motor_step)
		else $error("step edge did not produce one step");
	a_step_single: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_STEP_DIR && motor_step) |=> !motor_step)
		else $error("step held longer than one cycle");
	a_dir_from_sense: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_STEP_DIR && s_step && !step_prev_q)
		|=> (motor_dir == $past(s_sense)))
		else $error("direction not taken from sense");
	a_dir_low_pos: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_STEP_DIR && s_step && !step_prev_q && !s_sense)
		|=> motor_dir == SDRI_DIR_POS)
		else $error("low sense did not give positive direction");
	a_ready_needs_wait: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(drive_ready_n_oe) |-> $past(rdy_q) == SDRI_RDY_WAIT && $past(cnt_q) == READY_LAST)
		else $error("ready asserted before delay");
	a_ready_pulls_low: assert property (@(posedge mclk) disable iff (sys_rst)
		drive_ready_n_oe |-> drive_ready_n_o == 1'b0)
		else $error("ready output not pulling low");
	a_error_drops: assert property (@(posedge mclk) disable iff (sys_rst)
		drive_error |=> !drive_ready_n_oe)
		else $error("ready held during error");
	a_quad_step: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_QUAD && quad[1]) |=> motor_step && motor_dir == $past(quad[0]))
		else $error("quadrature edge not counted");
	a_quad_index: assert property (@(posedge mclk) disable iff (sys_rst)
		(ref_mode == SDRI_MODE_QUAD && s_idx && !idx_prev_q) |=> index_seen)
		else $error("index pulse missed");
endmodule : sdri_top
`default_nettype wire

/* File: testbench/sdri_ctrl_model.sv */
// motion controller model driving step/direction or quadrature references
`timescale 1ns/1ps
`default_nettype none
module sdri_ctrl_model
	import sdri_pkg::*;
(
	input wire logic mclk,
	output var logic step_strobe,
	output var logic rotation_sense,
	output var logic ref_channel_a,
	output var logic ref_channel_b,
	output var logic ref_index
);
	// all lines idle low, sense low reads as positive
	initial begin
		step_strobe = 1'b0;
		rotation_sense = 1'b0;
		ref_channel_a = 1'b0;
		ref_channel_b = 1'b0;
		ref_index = 1'b0;
	end
	// hold each level for the minimum edge spacing, called at the falling edge
	task automatic gap();
		repeat (SDRI_MIN_EDGE_CYCLES) @(negedge mclk);
	endtask : gap
	// one strobe with direction set up well ahead of the rise
	task automatic do_step(input logic dir);
		rotation_sense = dir;
		gap();
		step_strobe = 1'b1;
		gap();
		step_strobe = 1'b0;
		gap();
	endtask : do_step
	// one full quadrature cycle, forward has a leading b
	task automatic do_quad(input logic fwd);
		logic [1:0] seq [4];
		logic [1:0] p;
		seq = '{2'h1, 2'h3, 2'h2, 2'h0};
		for (int i = 0; i < 4; i++) begin
			p = fwd ? seq[i] : seq[(6 - i) % 4];
			{ref_channel_a, ref_channel_b} = p;
			gap();
		end
	endtask : do_quad
	// single index pulse
	task automatic do_index();
		ref_index = 1'b1;
		gap();
		ref_index = 1'b0;
		gap();
	endtask : do_index
endmodule : sdri_ctrl_model
`default_nettype wire

/* File: testbench/sdri_tb_top.sv */
// self-checking bench for the reference input block
`timescale 1ns/1ps
`default_nettype none
module sdri_tb_top;
	import sdri_pkg::*;
	localparam int RDY = 20;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	sdri_mode_t ref_mode = SDRI_MODE_STEP_DIR;
	logic stage_enable = 1'b0;
	logic drive_error = 1'b0;
	logic step_strobe, rotation_sense, ref_channel_a, ref_channel_b, ref_index;
	logic motor_step, motor_dir, index_seen, rdy_o, rdy_oe;
	wire drive_ready_n = rdy_oe ? rdy_o : 1'b1; // pull-up when floating
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [15:0] n_steps = 16'h0000;
	logic [15:0] n_index = 16'h0000;
	logic last_dir = 1'b0;
	always #50 mclk = ~mclk;
	sdri_ctrl_model ctrl (.mclk(mclk), .step_strobe(step_strobe),
		.rotation_sense(rotation_sense), .ref_channel_a(ref_channel_a),
		.ref_channel_b(ref_channel_b), .ref_index(ref_index));
	sdri_top #(.READY_CYCLES(RDY)) DUT (.mclk(mclk), .sys_rst(sys_rst), .ref_mode(ref_mode),
		.step_strobe(step_strobe), .rotation_sense(rotation_sense),
		.ref_channel_a(ref_channel_a), .ref_channel_b(ref_channel_b), .ref_index(ref_index),
		.stage_enable(stage_enable), .drive_error(drive_error), .motor_step(motor_step),
		.motor_dir(motor_dir), .index_seen(index_seen), .drive_ready_n_o(rdy_o),
		.drive_ready_n_oe(rdy_oe));
	// count step and index pulses, keep the direction of the last step
	always @(posedge mclk) begin
		cycles++;
		if (motor_step === 1'b1) begin
			n_steps++;
			last_dir = motor_dir;
		end
		if (index_seen === 1'b1) n_index++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// steps in both directions: one positive angle step, then two negative ones
	task automatic test_step_dir();
		logic [15:0] base;
		base = n_steps;
		ctrl.do_step(SDRI_DIR_POS);
		chk(n_steps, base + 16'h0001);
		chk({15'h0000, last_dir}, {15'h0000, SDRI_DIR_POS});
		ctrl.do_step(SDRI_DIR_NEG);
		ctrl.do_step(SDRI_DIR_NEG);
		chk(n_steps, base + 16'h0003);
		chk({15'h0000, last_dir}, {15'h0000, SDRI_DIR_NEG});
	endtask : test_step_dir
	// quadrature forward then reverse, plus index
	task automatic test_quad();
		logic [15:0] base;
		ref_mode = SDRI_MODE_QUAD;
		repeat (5) @(negedge mclk);
		base = n_steps;
		ctrl.do_quad(1'b1);
		chk(n_steps, base + 16'h0004);
		chk({15'h0000, last_dir}, {15'h0000, SDRI_DIR_POS});
		ctrl.do_quad(1'b0);
		chk(n_steps, base + 16'h0008);
		chk({15'h0000, last_dir}, {15'h0000, SDRI_DIR_NEG});
		ctrl.do_index();
		chk(n_index, 16'h0001);
	endtask : test_quad
	// ready delay, open-collector level, error removes and restarts readiness
	task automatic test_ready();
		stage_enable = 1'b1;
		repeat (RDY) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0001);
		repeat (3) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0000);
		drive_error = 1'b1;
		repeat (3) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0001);
		drive_error = 1'b0;
		repeat (RDY) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0001);
		repeat (3) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0000);
	endtask : test_ready
	initial begin
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		chk({15'h0000, drive_ready_n}, 16'h0001);
		test_step_dir();
		test_quad();
		test_ready();
		print_verdict();
	end
endmodule : sdri_tb_top
`default_nettype wire
